// File: core/mdl_link.sv
// Modulator side of the DAC link: bit clock, data lines, mute line and control registers.
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "mdl_defs.svh"
module mdl_link
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [`MDL_ADDR_W-1:0]   addr_i,
  input  wire logic [`MDL_DATA_W-1:0]   wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [`MDL_DATA_W-1:0]   rdata_o,
  input  wire logic                     modulator_master_clock_input_i,
  input  wire logic                     external_mute_input_i,
  input  wire logic [`MDL_LINES-1:0]    left_word_i,
  input  wire logic [`MDL_LINES-1:0]    right_word_i,
  output logic                          word_take_o,
  output logic                          bit_clock_output_o,
  output logic      [`MDL_LINES-1:0]    modulator_data_lines_o,
  output logic                          mute_release_line_o
);
  import mdl_pkg::*;

  // Base master clock frequency in hertz for the selected rate family.
  function automatic logic [23:0] base_clock_frequency(input logic family);
    logic [23:0] base_sample_rate;
    base_sample_rate = family ? 24'(`MDL_FSB_44K1_HZ) : 24'(`MDL_FSB_48K_HZ);
    return 24'(`MDL_MCLK_BASE_MULT * base_sample_rate);
  endfunction

  mdl_mute_if mif();

  logic                   mclk_s1;
  logic                   mclk_s2;
  logic                   mclk_s3;
  logic                   external_mute_input_s1;
  logic                   external_mute_input_s2;

  logic [`MDL_DATA_W-1:0] device_select_field;
  logic [`MDL_DATA_W-1:0] next_device_select_field;
  logic [`MDL_DATA_W-1:0] ctrl;
  logic [`MDL_DATA_W-1:0] next_ctrl;
  logic [`MDL_DATA_W-1:0] modreg;
  logic [`MDL_DATA_W-1:0] next_modreg;
  logic                   cfg_change;
  logic                   next_cfg_change;
  logic [`MDL_DATA_W-1:0] rdata;
  logic [`MDL_DATA_W-1:0] next_rdata;

  logic                   dac_bit_clock_input;
  logic                   next_bck;
  logic [`MDL_LINES-1:0]  lines;
  logic [`MDL_LINES-1:0]  next_lines;
  logic                   phase;
  logic                   next_phase;
  logic                   take;
  logic                   next_take;
  mdl_count_type          idle;
  mdl_count_type          next_idle;

  logic                   bit_clock_ratio_select;
  logic                   output_stereo_mode_bit;
  logic                   rate_family;
  logic [1:0]             modulator_select_field;
  logic [1:0]             output_bit_width_field;
  logic                   mclk_rise;
  logic                   mclk_fall;
  logic                   tick;
  logic                   in_spec;
  logic [23:0]            freq;

  // The master clock and the abnormal flag are foreign to clk_i.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mclk_s1  <= 1'b0;
      mclk_s2  <= 1'b0;
      mclk_s3  <= 1'b0;
      external_mute_input_s1 <= 1'b0;
      external_mute_input_s2 <= 1'b0;
    end
    else
    begin
      mclk_s1  <= modulator_master_clock_input_i;
      mclk_s2  <= mclk_s1;
      mclk_s3  <= mclk_s2;
      external_mute_input_s1 <= external_mute_input_i;
      external_mute_input_s2 <= external_mute_input_s1;
    end
  end

  assign bit_clock_ratio_select = ctrl[`MDL_CTRL_RATIO];
  assign output_stereo_mode_bit = ctrl[`MDL_CTRL_STEREO];
  assign rate_family            = ctrl[`MDL_CTRL_FAMILY];
  assign modulator_select_field = modreg[`MDL_MOD_SEL_LO +: 2];
  assign output_bit_width_field = modreg[`MDL_MOD_WIDTH_LO +: 2];
  assign in_spec                = (modulator_select_field == 2'h0) && (output_bit_width_field == 2'h0);
  assign freq                   = base_clock_frequency(rate_family);

  // Register writes; a change of ratio, format or family forces a mute cycle.
  always_comb
  begin
    next_device_select_field = device_select_field;
    next_ctrl                = ctrl;
    next_modreg              = modreg;
    next_cfg_change          = 1'b0;
    if (wr_i)
    begin
      unique case (addr_i)
        `MDL_REG_DEVSEL:
        begin
          next_device_select_field = wdata_i;
        end
        `MDL_REG_CTRL:
        begin
          next_ctrl       = {4'h0, wdata_i[3:0]};
          next_cfg_change = (wdata_i[2:0] != ctrl[2:0]);
        end
        `MDL_REG_MOD:
        begin
          next_modreg = {4'h0, wdata_i[3:0]};
        end
        default:
        begin
          next_device_select_field = device_select_field;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      device_select_field <= `MDL_DEVSEL_RESET;
      ctrl                <= `MDL_CTRL_RESET;
      modreg              <= `MDL_MOD_RESET;
      cfg_change          <= 1'b0;
    end
    else
    begin
      device_select_field <= next_device_select_field;
      ctrl                <= next_ctrl;
      modreg              <= next_modreg;
      cfg_change          <= next_cfg_change;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_comb
  begin
    next_rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        `MDL_REG_DEVSEL:
        begin
          next_rdata = device_select_field;
        end
        `MDL_REG_CTRL:
        begin
          next_rdata = ctrl;
        end
        `MDL_REG_MOD:
        begin
          next_rdata = modreg;
        end
        `MDL_REG_STATUS:
        begin
          next_rdata = {3'h0, in_spec, mif.settling, mif.clk_ok, external_mute_input_s2, mif.release_line};
        end
        `MDL_REG_FREQ0:
        begin
          next_rdata = freq[7:0];
        end
        `MDL_REG_FREQ1:
        begin
          next_rdata = freq[15:8];
        end
        `MDL_REG_FREQ2:
        begin
          next_rdata = freq[23:16];
        end
        default:
        begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Master clock edges drive the bit clock: one toggle per rising edge gives 128fs,
  // one toggle per edge of either kind gives 256fs.
  assign mclk_rise = mclk_s2 && !mclk_s3;
  assign mclk_fall = !mclk_s2 && mclk_s3;
  assign tick      = bit_clock_ratio_select ? (mclk_rise || mclk_fall) : mclk_rise;

  // Data change on the falling bit clock edge so the DAC can take them on the rising one.
  // Data are zeroed at each bit clock fall taken while muted, which keeps the DAC input quiet during initialisation.
  always_comb
  begin
    next_bck   = dac_bit_clock_input;
    next_lines = lines;
    next_phase = phase;
    next_take  = 1'b0;
    next_idle  = idle;
    if (mclk_rise || mclk_fall)
    begin
      next_idle = '0;
    end
    else if (idle != 12'(`MDL_MCLK_TIMEOUT_CYC))
    begin
      next_idle = idle + 12'h001;
    end
    if (tick)
    begin
      next_bck = !dac_bit_clock_input;
      if (dac_bit_clock_input)
      begin
        if (output_stereo_mode_bit)
        begin
          next_lines = phase ? right_word_i : left_word_i;
          next_phase = !phase;
          next_take  = phase;
        end
        else
        begin
          next_lines = left_word_i;
          next_phase = 1'b0;
          next_take  = 1'b1;
        end
        if (!mif.release_line)
        begin
          next_lines = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_bit_clock_input   <= 1'b0;
      lines <= '0;
      phase <= 1'b0;
      take  <= 1'b0;
      idle  <= '0;
    end
    else
    begin
      dac_bit_clock_input   <= next_bck;
      lines <= next_lines;
      phase <= next_phase;
      take  <= next_take;
      idle  <= next_idle;
    end
  end

  assign mif.soft_release = ctrl[`MDL_CTRL_RELEASE];
  assign mif.ext_mute     = external_mute_input_s2;
  assign mif.devsel_ok    = (device_select_field == `MDL_DEVSEL_CODE);
  assign mif.clk_ok       = (idle != 12'(`MDL_MCLK_TIMEOUT_CYC));
  assign mif.cfg_change   = cfg_change;

  mdl_mute_seq u_mute
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mif   (mif)
  );

  assign rdata_o                = rdata;
  assign word_take_o            = take;
  assign bit_clock_output_o     = dac_bit_clock_input;
  assign modulator_data_lines_o = lines;
  assign mute_release_line_o    = mif.release_line;
endmodule

// File: inc/mdl_defs.svh
// Offsets, field positions, reset values and timing counts of the modulator link.
// Overview of operation
// - Device select field must hold 21H; the DAC select is 0100 or pin high.
// - Bit clock runs at 128 or 256 times sample rate per ratio select.
// - Seven data lines carry stereo or mono per the output stereo mode bit.
// - Bit clock drives DAC bit clock; each data line drives same-index DAC input.
// - Modulator select and output bit width fields must be 00 for rated performance.
// - Modulator mute output drives the DAC mute input to silence source switches.
// - External abnormal flag on the mute input forces the DAC muted.
// - Clocks and ratio change only while muted; a ratio write here applies at once and the mute line drops a cycle later; release waits for stable clocks.
// - Base master clock frequency is 256 times the base sample rate.
// - Base sample rate is 48 kHz or 44.1 kHz depending on rate family.
`ifndef MDL_DEFS_SVH
`define MDL_DEFS_SVH

`define MDL_ADDR_W            4
`define MDL_DATA_W            8
`define MDL_LINES             7

`define MDL_REG_DEVSEL        4'h0
`define MDL_REG_CTRL          4'h1
`define MDL_REG_MOD           4'h2
`define MDL_REG_STATUS        4'h3
`define MDL_REG_FREQ0         4'h4
`define MDL_REG_FREQ1         4'h5
`define MDL_REG_FREQ2         4'h6

`define MDL_CTRL_RATIO        0
`define MDL_CTRL_STEREO       1
`define MDL_CTRL_FAMILY       2
`define MDL_CTRL_RELEASE      3
`define MDL_MOD_SEL_LO        0
`define MDL_MOD_WIDTH_LO      2

`define MDL_DEVSEL_RESET      8'h21
`define MDL_DEVSEL_CODE       8'h21
`define MDL_CTRL_RESET        8'h00
`define MDL_MOD_RESET         8'h00

`define MDL_FSB_48K_HZ        48000
`define MDL_FSB_44K1_HZ       44100
`define MDL_MCLK_BASE_MULT    256

`define MDL_CLK_MHZ           250
`define MDL_SETTLE_NS         10000
`define MDL_SETTLE_CYC        (((`MDL_SETTLE_NS * `MDL_CLK_MHZ) + 999) / 1000)
`define MDL_MCLK_TIMEOUT_NS   256
`define MDL_MCLK_TIMEOUT_CYC  ((`MDL_MCLK_TIMEOUT_NS * `MDL_CLK_MHZ) / 1000)

`endif

// File: inc/mdl_pkg.sv
// Types shared by the modulator link modules.
package mdl_pkg;

  typedef enum logic [1:0]
  {
    MDL_MUTED,
    MDL_SETTLE,
    MDL_RUN
  } mdl_mute_state_type;

  typedef logic [11:0] mdl_count_type;

endpackage

// File: inc/mdl_mute_if.sv
// Signals between the link top and its mute sequencer.
interface mdl_mute_if;
  logic soft_release;
  logic ext_mute;
  logic devsel_ok;
  logic clk_ok;
  logic cfg_change;
  logic release_line;
  logic settling;

  modport ctl
  (
    output soft_release,
    output ext_mute,
    output devsel_ok,
    output clk_ok,
    output cfg_change,
    input  release_line,
    input  settling
  );

  modport seq
  (
    input  soft_release,
    input  ext_mute,
    input  devsel_ok,
    input  clk_ok,
    input  cfg_change,
    output release_line,
    output settling
  );
endinterface

// File: core/mdl_mute_seq.sv
// Mute sequencer that holds the mute line low until clocks and settings are settled.
`include "mdl_defs.svh"
module mdl_mute_seq
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  mdl_mute_if.seq    mif
);
  import mdl_pkg::*;

  mdl_mute_state_type state;
  mdl_mute_state_type next_state;
  mdl_count_type      count;
  mdl_count_type      next_count;
  logic               release_q;
  logic               next_release_q;
  logic               settling_q;
  logic               next_settling_q;
  logic               go;

  // Any loss of a condition drops mute at once; a new settle time starts afterwards.
  always_comb
  begin
    go = mif.soft_release && !mif.ext_mute && mif.devsel_ok && mif.clk_ok && !mif.cfg_change;
    next_state = state;
    next_count = count;
    unique case (state)
      MDL_MUTED:
      begin
        next_count = '0;
        if (go)
        begin
          next_state = MDL_SETTLE;
        end
      end
      MDL_SETTLE:
      begin
        if (!go)
        begin
          next_state = MDL_MUTED;
        end
        else if (count == 12'(`MDL_SETTLE_CYC - 1))
        begin
          next_state = MDL_RUN;
        end
        else
        begin
          next_count = count + 12'h001;
        end
      end
      MDL_RUN:
      begin
        if (!go)
        begin
          next_state = MDL_MUTED;
        end
      end
    endcase
    next_release_q  = (next_state == MDL_RUN);
    next_settling_q = (next_state == MDL_SETTLE);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= MDL_MUTED;
      count      <= '0;
      release_q  <= 1'b0;
      settling_q <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      count      <= next_count;
      release_q  <= next_release_q;
      settling_q <= next_settling_q;
    end
  end

  assign mif.release_line = release_q;
  assign mif.settling     = settling_q;
endmodule

// File: sim/mdl_link_chk.sv
// Port checker for the modulator link, bound to its top module.
`include "mdl_defs.svh"
module mdl_link_chk
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic [`MDL_ADDR_W-1:0] addr_i,
  input wire logic [`MDL_DATA_W-1:0] wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [`MDL_DATA_W-1:0] rdata_o,
  input wire logic                   modulator_master_clock_input_i,
  input wire logic                   external_mute_input_i,
  input wire logic                   bit_clock_output_o,
  input wire logic [`MDL_LINES-1:0]  modulator_data_lines_o,
  input wire logic                   mute_release_line_o
);
  localparam int SETTLE = `MDL_SETTLE_CYC - 1;
  logic        ratio;
  logic        next_ratio;
  logic [7:0]  devsel;
  logic [7:0]  next_devsel;
  logic [11:0] low_cnt;
  logic [11:0] next_low_cnt;
  logic [7:0]  mhist;
  logic [7:0]  next_mhist;

  // The master clock pin is asynchronous, so edges are accepted over a small window of delays.
  always_comb
  begin
    next_ratio = (wr_i && addr_i == `MDL_REG_CTRL) ? wdata_i[0] : ratio;
    next_devsel = (wr_i && addr_i == `MDL_REG_DEVSEL) ? wdata_i : devsel;
    next_low_cnt = mute_release_line_o ? 12'h000 : ((low_cnt == 12'hFFF) ? low_cnt : low_cnt + 12'h001);
    next_mhist = {mhist[6:0], modulator_master_clock_input_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ratio <= 1'b0;
      devsel <= `MDL_DEVSEL_RESET;
      low_cnt <= 12'h000;
      mhist <= 8'h00;
    end
    else
    begin
      ratio <= next_ratio;
      devsel <= next_devsel;
      low_cnt <= next_low_cnt;
      mhist <= next_mhist;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_release;
    $rose(mute_release_line_o);
  endsequence
  sequence s_ext_raise;
    $rose(external_mute_input_i);
  endsequence

  // Lines are cleared at the first bit clock fall taken while muted, not at the mute edge itself.
  a_lines_zero_muted: assert property ($fell(bit_clock_output_o) && !$past(mute_release_line_o)
    |-> modulator_data_lines_o == 7'h00)
    else $error("data lines active while muted");
  a_lines_on_fall: assert property (mute_release_line_o && $past(mute_release_line_o)
    && $changed(modulator_data_lines_o) |-> $fell(bit_clock_output_o))
    else $error("data lines changed away from a bit clock fall");
  a_ext_forces_mute: assert property (s_ext_raise |-> ##[1:6] !mute_release_line_o)
    else $error("external mute did not mute the link");
  a_settle_release: assert property (s_release |-> low_cnt >= SETTLE)
    else $error("mute released before settling time");
  a_devsel_hold: assert property (s_release |-> devsel == `MDL_DEVSEL_CODE)
    else $error("mute released with wrong device select");
  a_bck_follows_mclk: assert property ($changed(bit_clock_output_o) |-> |(mhist[5:1] ^ mhist[6:2]))
    else $error("bit clock moved without a master clock edge");
  a_slow_ratio_rise: assert property ($changed(bit_clock_output_o) && !ratio && !$past(ratio, 8)
    |-> |(mhist[5:1] & ~mhist[6:2]))
    else $error("bit clock toggled without a master clock rise");
  a_status_mute: assert property ($past(rd_i) && $past(addr_i) == `MDL_REG_STATUS
    |-> rdata_o[0] == $past(mute_release_line_o))
    else $error("status mute bit differs from mute line");
  a_ratio_mutes: assert property (wr_i && addr_i == `MDL_REG_CTRL && wdata_i[0] != ratio
    |-> ##[1:4] !mute_release_line_o)
    else $error("ratio change did not mute the link");
endmodule

bind mdl_link mdl_link_chk mdl_link_chk_i (.*);

// File: sim/mdl_dac_model.sv
// Behavioural receiving DAC that samples the data lines on bit clock rises.
module mdl_dac_model
(
  input  wire logic       bck_i,
  input  wire logic [6:0] lines_i,
  input  wire logic       mute_i,
  output logic      [6:0] word_o,
  output logic      [6:0] prev_o,
  output int              count_o,
  output int              inits_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    word_o = 7'h00;
    prev_o = 7'h00;
    count_o = 0;
    inits_o = 0;
  end
  // Sampling on the rise leaves half a bit period of margin after each fall update.
  always @(posedge bck_i)
  begin
    prev_o <= word_o;
    word_o <= lines_i;
    count_o <= count_o + 1;
  end
  always @(posedge mute_i)
    inits_o <= inits_o + 1;
endmodule

// File: sim/mdl_link_tb.sv
// Self-checking bench for the modulator link.
`include "mdl_defs.svh"
module mdl_link_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       modulator_master_clock_input_i = 1'b0;
  logic       external_mute_input_i = 1'b0;
  logic [6:0] left_word_i = 7'h55;
  logic [6:0] right_word_i = 7'h2A;
  logic       word_take_o;
  logic       bit_clock_output_o;
  logic [6:0] modulator_data_lines_o;
  logic       mute_release_line_o;
  logic       mclk_run = 1'b1;
  logic [6:0] word;
  logic [6:0] prev;
  int         count;
  int         inits;
  int         mismatches = 0;
  int         comparisons = 0;
  logic [7:0] d;

  always #2 clk_i = ~clk_i;
  // Both clocks come from the bench timebase, so they stay related in frequency.
  always #62.5 modulator_master_clock_input_i = mclk_run ? ~modulator_master_clock_input_i : 1'b0;

  mdl_link mdl_link_i (.*);
  mdl_dac_model mdl_dac_model_i (.bck_i(bit_clock_output_o), .lines_i(modulator_data_lines_o),
    .mute_i(mute_release_line_o), .word_o(word), .prev_o(prev), .count_o(count), .inits_o(inits));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    chk(d & e, e);
    chk(d, e);
  endtask

  task automatic wait_mute(input logic lvl, input int lim);
    int n;
    n = 0;
    while (mute_release_line_o !== lvl && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (mute_release_line_o !== lvl)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic t_regs();
    rdchk(`MDL_REG_DEVSEL, `MDL_DEVSEL_CODE);
    rdchk(`MDL_REG_CTRL, 8'h00);
    wr(`MDL_REG_MOD, 8'hFF);
    rdchk(`MDL_REG_MOD, 8'h0F);
    rdchk(`MDL_REG_STATUS, 8'h04);
    wr(`MDL_REG_MOD, 8'h00);
    rdchk(`MDL_REG_STATUS, 8'h14);
    rdchk(4'h9, 8'h00);
    rdchk(`MDL_REG_FREQ0, 8'h00);
    rdchk(`MDL_REG_FREQ1, 8'h80);
    rdchk(`MDL_REG_FREQ2, 8'hBB);
    wr(`MDL_REG_CTRL, 8'h04);
    rdchk(`MDL_REG_FREQ1, 8'h44);
    rdchk(`MDL_REG_FREQ2, 8'hAC);
  endtask

  task automatic t_run(input logic r, input logic s);
    int i0;
    int c0;
    int t;
    i0 = inits;
    wr(`MDL_REG_CTRL, {4'h0, 2'b10, s, r});
    wait_mute(1'b0, 8);
    wait_mute(1'b1, 3000);
    chk(inits[7:0], i0[7:0] + 8'h01);
    c0 = count;
    t = 0;
    repeat (500)
    begin
      @(posedge clk_i);
      if (word_take_o === 1'b1)
        t++;
    end
    c0 = count - c0;
    chk({7'h00, c0 >= (r ? 15 : 7) && c0 <= (r ? 17 : 9)}, 8'h01);
    chk({7'h00, t >= (r ? 16 : 8) / (s ? 2 : 1) - 1 && t <= (r ? 16 : 8) / (s ? 2 : 1) + 1}, 8'h01);
    chk({1'b0, word ^ prev}, s ? 8'h7F : 8'h00);
    chk({7'h00, word != 7'h00}, 8'h01);
  endtask

  task automatic t_ext();
    int i0;
    i0 = inits;
    external_mute_input_i <= 1'b1;
    wait_mute(1'b0, 8);
    repeat (80) @(posedge clk_i);
    chk({1'b0, modulator_data_lines_o}, 8'h00);
    rdchk(`MDL_REG_STATUS, 8'h16);
    external_mute_input_i <= 1'b0;
    wait_mute(1'b1, 3000);
    chk(inits[7:0], i0[7:0] + 8'h01);
  endtask

  task automatic t_loss();
    mclk_run <= 1'b0;
    wait_mute(1'b0, 200);
    mclk_run <= 1'b1;
    wait_mute(1'b1, 3000);
    wr(`MDL_REG_DEVSEL, 8'h20);
    wait_mute(1'b0, 8);
    repeat (3000) @(posedge clk_i);
    chk({7'h00, mute_release_line_o}, 8'h00);
    wr(`MDL_REG_DEVSEL, `MDL_DEVSEL_CODE);
    wait_mute(1'b1, 3000);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_run(1'b0, 1'b0);
    t_run(1'b1, 1'b0);
    t_run(1'b1, 1'b1);
    t_run(1'b0, 1'b1);
    t_ext();
    t_loss();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({7'h00, mute_release_line_o}, 8'h00);
    t_regs();
    end_sim();
  end
endmodule
